// File: logic/etvo_video_out.sv
// Eight-tap video output sequencer: sensor-side line capture and pixel-clock link timing
`timescale 1ns/1ps
`default_nettype none
`include "etvo_regs.svh"
module etvo_video_out #(
  parameter int TAPS = `ETVO_TAPS,
  parameter int MAX_WORDS = `ETVO_MAX_WORDS
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pixel link clock
  input wire logic pix_clk,
  // Sensor samples, core clock domain
  input wire logic sen_valid,
  input wire logic sen_sof,
  input wire logic [`ETVO_ADC_W*`ETVO_TAPS-1:0] sen_pix,
  output logic sen_ready,
  // Frame configuration, taken at each start of frame
  input wire logic aoi_enable,
  input wire logic [10:0] aoi_start_col,
  input wire logic [10:0] aoi_width,
  input wire logic [10:0] aoi_height,
  input wire etvo_pkg::etvo_shift_t shift_sel,
  output logic [10:0] sensor_start_col,
  output logic cfg_reject,
  // Transmitter inputs, pixel clock domain
  output logic [`ETVO_PIX_W*`ETVO_TAPS-1:0] pix_stream,
  output logic serializer_input_24,
  output logic serializer_input_25,
  output logic link_underrun
);
  import etvo_pkg::*;

  localparam int PW = `ETVO_PIX_W;
  localparam int AW = `ETVO_ADC_W;
  localparam int DW = PW * TAPS;
  localparam int MAW = 9;
  localparam logic [7:0] FULL_WORDS = 8'(`ETVO_MAX_WORDS);
  localparam logic [10:0] FULL_ROWS = 11'(`ETVO_MAX_ROWS);
  localparam logic [1:0] LGAP_LAST = 2'(`ETVO_LINE_GAP - 1);
  localparam logic [1:0] FGAP_LAST = 2'(`ETVO_FRAME_GAP - 1);

  // ==========================================================
  // Configuration check
  // ==========================================================
  logic col_ok;
  logic wid_ok;
  logic row_ok;
  logic cfg_ok;

  assign col_ok = (aoi_start_col == 11'h000) ||
                  (aoi_start_col % 11'(`ETVO_COL_STEP) == 11'(`ETVO_COL_OFS)); // RULE5
  assign wid_ok = (aoi_width != 11'h000) &&
                  (aoi_width % 11'(`ETVO_WIDTH_STEP) == 11'h000) && // RULE6
                  ({1'b0, aoi_start_col} + {1'b0, aoi_width} <= 12'(`ETVO_MAX_COLS + 1));
  assign row_ok = (aoi_height != 11'h000) && (aoi_height <= FULL_ROWS); // RULE3
  assign cfg_ok = col_ok && wid_ok && row_ok;

  // ==========================================================
  // Core side: capture lines into the ping-pong memory
  // ==========================================================
  logic [1:0] fill_tgl_r;
  logic [1:0] drain_meta_r;
  logic [1:0] drain_sync_r;
  logic [1:0] drain_tgl_r;
  logic [1:0] full_c;
  logic wb_r;
  logic [7:0] wc_r;
  logic [10:0] rc_r;
  logic started_r;
  logic [7:0] words_cfg_r;
  logic [10:0] rows_cfg_r;
  etvo_shift_t shift_r;
  logic [1:0] first_r;
  logic [1:0] last_r;
  logic [1:0][7:0] meta_words_r;
  logic [7:0] words_new;
  logic [10:0] rows_new;
  logic use_aoi;
  logic [7:0] wc_cur;
  logic [10:0] rc_cur;
  logic [7:0] words_cur;
  logic [10:0] rows_cur;
  etvo_shift_t shift_cur;
  logic accept;
  logic wr_en;
  logic line_end;
  logic frame_end;
  logic [MAW-1:0] wr_addr;
  logic [DW-1:0] reduced;

  // Only the write side ever turns a bank full, so readiness can only improve
  assign full_c = fill_tgl_r ^ drain_sync_r;
  assign accept = sen_valid && sen_ready;
  assign wr_en = accept && (sen_sof || started_r);
  assign use_aoi = aoi_enable && cfg_ok; // RULE17
  assign words_new = use_aoi ? aoi_width[10:3] : FULL_WORDS;
  assign rows_new = use_aoi ? aoi_height : FULL_ROWS;
  assign wc_cur = sen_sof ? 8'h00 : wc_r;
  assign rc_cur = sen_sof ? 11'h000 : rc_r;
  assign words_cur = sen_sof ? words_new : words_cfg_r;
  assign rows_cur = sen_sof ? rows_new : rows_cfg_r;
  assign shift_cur = sen_sof ? shift_sel : shift_r;
  assign line_end = (wc_cur == words_cur - 8'h01);
  assign frame_end = line_end && (rc_cur == rows_cur - 11'h001);
  assign wr_addr = wb_r ? MAW'(MAX_WORDS) + MAW'(wc_cur) : MAW'(wc_cur);

  // Drop two of the ten bits; shifted settings clip at full scale
  genvar g;
  generate
    for (g = 0; g < TAPS; g++) begin : g_tap
      logic [AW-1:0] smp;
      logic [PW-1:0] red;
      assign smp = sen_pix[g*AW +: AW];
      always_comb begin
        case (shift_cur)
          SHIFT_NONE: red = smp[9:2]; // RULE9
          SHIFT_ONE: red = smp[9] ? 8'hFF : smp[8:1];
          default: red = (|smp[9:8]) ? 8'hFF : smp[7:0];
        endcase
      end
      assign reduced[g*PW +: PW] = red; // RULE13
    end
  endgenerate

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drain_meta_r <= 2'b00;
      drain_sync_r <= 2'b00;
    end else begin
      drain_meta_r <= drain_tgl_r;
      drain_sync_r <= drain_meta_r;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sen_ready <= 1'b0;
    end else if (accept && line_end) begin
      sen_ready <= ~full_c[~wb_r];
    end else begin
      sen_ready <= ~full_c[wb_r];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      words_cfg_r <= FULL_WORDS;
      rows_cfg_r <= FULL_ROWS;
      shift_r <= SHIFT_NONE;
      sensor_start_col <= 11'h000;
      cfg_reject <= 1'b0;
    end else begin
      cfg_reject <= accept && sen_sof && aoi_enable && !cfg_ok;
      if (accept && sen_sof) begin
        words_cfg_r <= words_new;
        rows_cfg_r <= rows_new;
        shift_r <= shift_sel;
        sensor_start_col <= use_aoi ? aoi_start_col : 11'h000;
      end
    end
  end

  // Lines are written in sensor order, so the link reads them top to bottom
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_r <= 1'b0;
      wc_r <= 8'h00;
      rc_r <= 11'h000;
      started_r <= 1'b0;
      fill_tgl_r <= 2'b00;
      first_r <= 2'b00;
      last_r <= 2'b00;
      meta_words_r <= '0;
    end else if (wr_en) begin
      if (line_end) begin
        fill_tgl_r[wb_r] <= ~fill_tgl_r[wb_r]; // RULE7
        first_r[wb_r] <= (rc_cur == 11'h000);
        last_r[wb_r] <= frame_end;
        meta_words_r[wb_r] <= words_cur;
        wb_r <= ~wb_r;
        wc_r <= 8'h00;
        rc_r <= rc_cur + 11'h001;
        started_r <= !frame_end;
      end else begin
        wc_r <= wc_cur + 8'h01;
        rc_r <= rc_cur;
        started_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Line memory, two banks of one full line each
  // ==========================================================
  logic rd_en;
  logic [MAW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  etvo_line_mem #(
    .WIDTH(DW),
    .DEPTH(2 * MAX_WORDS),
    .AW(MAW)
  ) etvo_line_mem_inst (
    .wr_clk(core_clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(reduced),
    .rd_clk(pix_clk),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ==========================================================
  // Link side: frame and line timing on the pixel clock
  // ==========================================================
  logic lrst_meta_r;
  logic lrst_r;
  logic [1:0] fill_meta_r;
  logic [1:0] fill_sync_r;
  logic [1:0] full_l;
  logic rb_r;
  logic [7:0] w_r;
  logic [1:0] gcnt_r;
  etvo_lnk_state_t state_r;
  logic fv0;
  logic lv0;
  logic fv1_r;
  logic lv1_r;
  logic last_word;

  // Reset asserts at once but releases in step with the pixel clock
  always_ff @(posedge pix_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lrst_meta_r <= 1'b1;
      lrst_r <= 1'b1;
    end else begin
      lrst_meta_r <= 1'b0;
      lrst_r <= lrst_meta_r;
    end
  end

  always_ff @(posedge pix_clk or posedge lrst_r) begin
    if (lrst_r) begin
      fill_meta_r <= 2'b00;
      fill_sync_r <= 2'b00;
    end else begin
      fill_meta_r <= fill_tgl_r;
      fill_sync_r <= fill_meta_r;
    end
  end

  // Bank metadata is written with the fill toggle and only read once it is seen
  assign full_l = fill_sync_r ^ drain_tgl_r;
  assign last_word = (w_r == meta_words_r[rb_r] - 8'h01); // RULE4
  assign fv0 = (state_r == LNK_LEAD) || (state_r == LNK_LINE) || (state_r == LNK_GAP);
  assign lv0 = (state_r == LNK_LINE);
  assign rd_en = lv0;
  assign rd_addr = rb_r ? MAW'(MAX_WORDS) + MAW'(w_r) : MAW'(w_r);

  always_ff @(posedge pix_clk or posedge lrst_r) begin
    if (lrst_r) begin
      state_r <= LNK_IDLE;
      rb_r <= 1'b0;
      w_r <= 8'h00;
      gcnt_r <= 2'b00;
      drain_tgl_r <= 2'b00;
    end else begin
      case (state_r)
        LNK_IDLE: begin
          if (full_l[rb_r] && first_r[rb_r]) begin
            state_r <= LNK_LEAD; // RULE20
          end else if (full_l[rb_r]) begin
            // A stray mid-frame line is discarded to regain frame alignment
            drain_tgl_r[rb_r] <= ~drain_tgl_r[rb_r];
            rb_r <= ~rb_r;
          end
        end
        LNK_LEAD: begin
          state_r <= LNK_LINE; // RULE12
          w_r <= 8'h00;
        end
        LNK_LINE: begin
          if (last_word) begin
            drain_tgl_r[rb_r] <= ~drain_tgl_r[rb_r]; // RULE11
            rb_r <= ~rb_r;
            gcnt_r <= 2'b00;
            state_r <= last_r[rb_r] ? LNK_FEND : LNK_GAP; // RULE15
          end else begin
            w_r <= w_r + 8'h01;
          end
        end
        LNK_GAP: begin
          if (gcnt_r != LGAP_LAST) begin
            gcnt_r <= gcnt_r + 2'b01;
          end else if (full_l[rb_r]) begin
            state_r <= LNK_LINE; // RULE14
            w_r <= 8'h00;
          end
        end
        LNK_FEND: begin
          if (gcnt_r == FGAP_LAST) begin
            state_r <= LNK_IDLE; // RULE16
          end else begin
            gcnt_r <= gcnt_r + 2'b01;
          end
        end
        default: begin
          state_r <= LNK_IDLE;
        end
      endcase
    end
  end

  // Flags are delayed one stage so they stay aligned with the memory read
  always_ff @(posedge pix_clk or posedge lrst_r) begin
    if (lrst_r) begin
      fv1_r <= 1'b0;
      lv1_r <= 1'b0;
    end else begin
      fv1_r <= fv0;
      lv1_r <= lv0;
    end
  end

  always_ff @(posedge pix_clk or posedge lrst_r) begin
    if (lrst_r) begin
      serializer_input_24 <= 1'b0;
      serializer_input_25 <= 1'b0;
      pix_stream <= '0;
    end else begin
      serializer_input_24 <= lv1_r; // RULE19
      serializer_input_25 <= fv1_r; // RULE10
      pix_stream <= lv1_r ? rd_data : '0; // RULE8 RULE1 RULE2
    end
  end

  // A late line stretches the gap; this flags that the four-cycle gap was missed
  always_ff @(posedge pix_clk or posedge lrst_r) begin
    if (lrst_r) begin
      link_underrun <= 1'b0;
    end else begin
      link_underrun <= (state_r == LNK_GAP) && (gcnt_r == LGAP_LAST) && !full_l[rb_r];
    end
  end
endmodule
`default_nettype wire

// File: logic/etvo_regs.svh
// Constants for the eight-tap video output sequencer
`ifndef ETVO_REGS_SVH
`define ETVO_REGS_SVH
// Summary of operation
// RULE1: Video leaves as eight parallel streams of one 8-bit pixel each per clock.
// RULE2: Pixel data and valid flags launch on every rising pixel clock edge.
// RULE3: Pixel clock is 67.58 MHz; image at most 1280 by 1024 pixels.
// RULE4: A full-width line occupies at most 160 pixel clocks with line valid high.
// RULE5: Area start column is accepted only as a multiple of ten plus one; the code also accepts column 0.
// RULE6: Area width is accepted only as a multiple of forty columns.
// RULE7: Lines go out in order, top-left pixel first, bottom-right pixel last.
// RULE8: Stream data carries image content only while line valid is high.
// RULE9: Each 10-bit sample loses two bits; a shift setting picks which two.
// RULE10: Both valid flags stay low whenever no valid data is being sent.
// RULE11: Sending a previous frame may overlap acquiring the next, or follow it.
// RULE12: Line valid rises one pixel clock after frame valid rises.
// RULE13: Pixel n of a line appears on stream n mod 8 in cycle n div 8.
// RULE14: Line valid stays low exactly four pixel clocks between lines of a frame; the code stretches the gap until the next line is stored.
// RULE15: After the last line frame valid falls together with line valid.
// RULE16: Frame valid stays low at least three pixel clocks between frames.
// RULE17: An enabled area of interest shortens lines and frames to that region.
// RULE18: The receiver picks its own capture edge; the device relies on nothing.
// RULE19: Line valid drives serializer input 24, frame valid serializer input 25.
// RULE20: After reset both flags stay low until a frame is ready to send.
`define ETVO_TAPS 8
`define ETVO_PIX_W 8
`define ETVO_ADC_W 10
`define ETVO_MAX_COLS 1280
`define ETVO_MAX_ROWS 1024
`define ETVO_MAX_WORDS 160
`define ETVO_LINE_GAP 4
`define ETVO_FRAME_GAP 3
`define ETVO_COL_STEP 10
`define ETVO_COL_OFS 1
`define ETVO_WIDTH_STEP 40
`define ETVO_PIX_CLK_KHZ 67580
`define ETVO_CORE_CLK_KHZ 125000
`endif

// File: logic/etvo_pkg.sv
// Types shared by the eight-tap video output sequencer
package etvo_pkg;
  typedef enum logic [2:0] {
    LNK_IDLE = 3'b000,
    LNK_LEAD = 3'b001,
    LNK_LINE = 3'b010,
    LNK_GAP = 3'b011,
    LNK_FEND = 3'b100
  } etvo_lnk_state_t;
  typedef enum logic [1:0] {
    SHIFT_NONE = 2'b00,
    SHIFT_ONE = 2'b01,
    SHIFT_TWO = 2'b10
  } etvo_shift_t;
endpackage

// File: logic/etvo_line_mem.sv
// Dual-clock line memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module etvo_line_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 320,
  parameter int AW = 9
) (
  // Write side
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_clk,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// File: dv/etvo_video_out_sva.sv
// Port-level checker for the eight-tap video output sequencer
`timescale 1ns/1ps
`default_nettype none
`include "etvo_regs.svh"
module etvo_video_out_sva #(
  parameter int MAX_WORDS = `ETVO_MAX_WORDS
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pix_clk,
  // Sensor side
  input wire logic sen_valid,
  input wire logic sen_sof,
  input wire logic [`ETVO_ADC_W*`ETVO_TAPS-1:0] sen_pix,
  input wire logic sen_ready,
  // Configuration
  input wire logic aoi_enable,
  input wire logic [10:0] aoi_start_col,
  input wire logic [10:0] aoi_width,
  input wire logic [10:0] aoi_height,
  input wire etvo_pkg::etvo_shift_t shift_sel,
  input wire logic [10:0] sensor_start_col,
  input wire logic cfg_reject,
  // Link side
  input wire logic [`ETVO_PIX_W*`ETVO_TAPS-1:0] pix_stream,
  input wire logic serializer_input_24,
  input wire logic serializer_input_25,
  input wire logic link_underrun
);
  import etvo_pkg::*;
  logic lv;
  logic fv;
  logic sof_ok;
  logic bad;
  logic [15:0] run_r;
  assign lv = serializer_input_24;
  assign fv = serializer_input_25;
  assign sof_ok = sen_valid & sen_ready & sen_sof;
  assign bad = aoi_enable & (!(aoi_start_col == 11'h000 || aoi_start_col % 11'h00A == 11'h001)
    || aoi_width == 11'h000 || aoi_width % 11'h028 != 11'h000
    || {1'b0, aoi_start_col} + {1'b0, aoi_width} > 12'h501
    || aoi_height == 11'h000 || aoi_height > 11'h400);
  // Length of the current line valid run
  always_ff @(posedge pix_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 16'h0000;
    end else begin
      run_r <= lv ? run_r + 16'h0001 : 16'h0000;
    end
  end
  // ==========================================
  // Link framing
  sequence s_lead;
    !lv ##1 lv;
  endsequence
  sequence s_gap;
    (fv && !lv) [*4];
  endsequence
  AST_IDLE: assert property (@(posedge pix_clk) disable iff (sys_rst) !fv |-> !lv)
    else $error("line valid outside frame");
  AST_LEAD: assert property (@(posedge pix_clk) disable iff (sys_rst) $rose(fv) |-> s_lead)
    else $error("line valid not one cycle after frame valid");
  // Underrun leads line valid by two register stages
  AST_GAP: assert property (@(posedge pix_clk) disable iff (sys_rst)
    fv && $fell(lv) |-> s_gap ##1 (lv || $past(link_underrun, 2)))
    else $error("line gap not four cycles");
  AST_FEND: assert property (@(posedge pix_clk) disable iff (sys_rst) $fell(fv) |-> $fell(lv))
    else $error("frame valid fell apart from line valid");
  AST_FGAP: assert property (@(posedge pix_clk) disable iff (sys_rst) $fell(fv) |-> (!fv) [*3])
    else $error("frame gap under three cycles");
  AST_ZERO: assert property (@(posedge pix_clk) disable iff (sys_rst) !lv |-> pix_stream == '0)
    else $error("stream data outside line");
  AST_LINE: assert property (@(posedge pix_clk) disable iff (sys_rst) lv |-> run_r < MAX_WORDS)
    else $error("line longer than maximum");
  // ==========================================
  // Configuration
  AST_CFG: assert property (@(posedge core_clk) disable iff (sys_rst)
    sof_ok |=> cfg_reject == $past(bad)) else $error("config reject wrong");
  AST_START: assert property (@(posedge core_clk) disable iff (sys_rst) sof_ok |=>
    sensor_start_col == (($past(bad) || !$past(aoi_enable)) ? 11'h000 : $past(aoi_start_col)))
    else $error("start column wrong");
endmodule
bind etvo_video_out etvo_video_out_sva #(.MAX_WORDS(MAX_WORDS)) etvo_video_out_sva_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .pix_clk(pix_clk), .sen_valid(sen_valid),
  .sen_sof(sen_sof), .sen_pix(sen_pix), .sen_ready(sen_ready), .aoi_enable(aoi_enable),
  .aoi_start_col(aoi_start_col), .aoi_width(aoi_width), .aoi_height(aoi_height),
  .shift_sel(shift_sel), .sensor_start_col(sensor_start_col), .cfg_reject(cfg_reject),
  .pix_stream(pix_stream), .serializer_input_24(serializer_input_24),
  .serializer_input_25(serializer_input_25), .link_underrun(link_underrun));
`default_nettype wire

// File: dv/etvo_grabber_model.sv
// Frame grabber model: captures link words, counts lines and frames
`timescale 1ns/1ps
`default_nettype none
module etvo_grabber_model (
  // Link inputs
  input wire logic pix_clk,
  input wire logic [63:0] pix_stream,
  input wire logic line_valid,
  input wire logic frame_valid,
  // Capture summary
  output int frames,
  output int lines,
  output int words
);
  logic [63:0] cap [0:63];
  int idx;
  int run;
  logic fv_d;
  initial begin
    frames = 0;
    lines = 0;
    words = 0;
    idx = 0;
    run = 0;
  end
  // Rising-edge capture; the link holds data a full cycle so either edge works
  always @(posedge pix_clk) begin
    fv_d <= frame_valid;
    if (frame_valid && fv_d === 1'b0) begin
      idx <= 0;
      lines <= 0;
    end
    if (line_valid) begin
      cap[idx[5:0]] <= pix_stream;
      idx <= idx + 1;
      run <= run + 1;
    end else if (run != 0) begin
      lines <= lines + 1;
      words <= run;
      run <= 0;
    end
    if (!frame_valid && fv_d === 1'b1) begin
      frames <= frames + 1;
    end
  end
endmodule
`default_nettype wire

// File: dv/eight_tap_video_out_test.sv
// Self-checking bench for the eight-tap video output sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module eight_tap_video_out_test;
  import etvo_pkg::*;
  typedef struct {logic [10:0] col, wid, hgt; etvo_shift_t sh; logic rej;} etvo_row_t;
  logic core_clk, sys_rst, pix_clk, sen_valid, sen_sof, sen_ready, aoi_enable, cfg_reject;
  logic [79:0] sen_pix;
  logic [10:0] aoi_start_col, aoi_width, aoi_height, sensor_start_col;
  etvo_shift_t shift_sel;
  logic [63:0] pix_stream;
  logic lv, fv, link_underrun;
  int err_total, tests_run, frames, lines, words;
  int underruns = 0;
  etvo_row_t rows [0:8] = '{'{11'h000, 11'h028, 11'h002, SHIFT_NONE, 1'b0},
    '{11'h00B, 11'h050, 11'h003, SHIFT_ONE, 1'b0}, '{11'h015, 11'h028, 11'h001, SHIFT_TWO, 1'b0},
    '{11'h001, 11'h078, 11'h002, SHIFT_TWO, 1'b0}, '{11'h00A, 11'h028, 11'h002, SHIFT_NONE, 1'b1},
    '{11'h00B, 11'h032, 11'h002, SHIFT_NONE, 1'b1}, '{11'h00B, 11'h000, 11'h002, SHIFT_ONE, 1'b1},
    '{11'h4D9, 11'h050, 11'h002, SHIFT_NONE, 1'b1}, '{11'h00B, 11'h028, 11'h000, SHIFT_TWO, 1'b1}};
  etvo_video_out etvo_video_out_inst (.core_clk(core_clk), .sys_rst(sys_rst), .pix_clk(pix_clk),
    .sen_valid(sen_valid), .sen_sof(sen_sof), .sen_pix(sen_pix), .sen_ready(sen_ready),
    .aoi_enable(aoi_enable), .aoi_start_col(aoi_start_col), .aoi_width(aoi_width),
    .aoi_height(aoi_height), .shift_sel(shift_sel), .sensor_start_col(sensor_start_col),
    .cfg_reject(cfg_reject), .pix_stream(pix_stream), .serializer_input_24(lv),
    .serializer_input_25(fv), .link_underrun(link_underrun));
  etvo_grabber_model etvo_grabber_model_inst (.pix_clk(pix_clk), .pix_stream(pix_stream),
    .line_valid(lv), .frame_valid(fv), .frames(frames), .lines(lines), .words(words));
  always #4 core_clk = ~core_clk;
  // Gap stretches seen on the link, expected only when the feed stalls
  always @(posedge pix_clk) if (link_underrun === 1'b1) underruns++;
  // Link clock offset so its edges never line up with the core clock
  initial begin
    pix_clk = 1'b0;
    #13;
    forever #32 pix_clk = ~pix_clk;
  end
  function automatic logic [7:0] red(input logic [9:0] s, input etvo_shift_t m);
    case (m)
      SHIFT_NONE: return s[9:2];
      SHIFT_ONE: return s[9] ? 8'hFF : s[8:1];
      default: return (s[9] | s[8]) ? 8'hFF : s[7:0];
    endcase
  endfunction
  function automatic logic [9:0] smp(input int l, input int w, input int k);
    return 10'(l * 97 + w * 29 + k * 71 + 5);
  endfunction
  task automatic beat(input logic sof, input logic [79:0] d);
    int n;
    n = 0;
    sen_valid = 1'b1;
    sen_sof = sof;
    sen_pix = d;
    do begin
      @(posedge core_clk);
      n++;
    end while (sen_ready !== 1'b1 && n < 4000);
    if (n >= 4000) `CHK("sen_ready", 1'b1, sen_ready)
    @(negedge core_clk);
  endtask
  task automatic send_frame(input etvo_row_t c, input int pause);
    logic [79:0] d;
    aoi_enable = 1'b1;
    aoi_start_col = c.col;
    aoi_width = c.wid;
    aoi_height = c.hgt;
    shift_sel = c.sh;
    for (int l = 0; l < (c.rej ? 1 : int'(c.hgt)); l++) begin
      for (int w = 0; w < (c.rej ? 1 : int'(c.wid) / 8); w++) begin
        for (int k = 0; k < 8; k++) d[10*k +: 10] = smp(l, w, k);
        beat(l == 0 && w == 0, d);
        if (l == 0 && w == 0) begin
          `CHK("cfg_reject", c.rej, cfg_reject)
          `CHK("start_col", c.rej ? 11'h000 : c.col, sensor_start_col)
        end
      end
      // A stalled feed between lines makes the link stretch its gap
      if (l + 1 < int'(c.hgt) && pause > 0) begin
        sen_valid = 1'b0;
        repeat (pause) @(negedge core_clk);
      end
    end
    sen_valid = 1'b0;
  endtask
  task automatic check_frame(input etvo_row_t c, input int target);
    logic [63:0] e;
    int n;
    n = 0;
    while (frames < target && n < 3000) begin
      @(posedge pix_clk);
      n++;
    end
    @(negedge core_clk);
    `CHK("frames", target, frames)
    `CHK("lines", int'(c.hgt), lines)
    `CHK("words", int'(c.wid) / 8, words)
    for (int l = 0; l < c.hgt; l++) begin
      for (int w = 0; w < c.wid / 8; w++) begin
        for (int k = 0; k < 8; k++) e[8*k +: 8] = red(smp(l, w, k), c.sh);
        `CHK("pixels", e, etvo_grabber_model_inst.cap[l*(c.wid/8)+w])
      end
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    $display("watchdog expired");
    complete_run;
  end
  initial begin
    int f0;
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {sen_valid, sen_sof, sen_pix, aoi_enable} = '0;
    {aoi_start_col, aoi_width, aoi_height} = '0;
    shift_sel = SHIFT_NONE;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(posedge pix_clk);
    @(negedge core_clk);
    `CHK("ready_in_reset", 1'b0, sen_ready)
    `CHK("fval_in_reset", 1'b0, fv)
    sys_rst = 1'b0;
    beat(1'b0, '1);
    sen_valid = 1'b0;
    repeat (60) @(negedge core_clk);
    `CHK("fval_stray_beat", 1'b0, fv)
    `CHK("lval_stray_beat", 1'b0, lv)
    $display("test reset done");
    for (int r = 0; r < 9; r++) begin
      send_frame(rows[r], 0);
      if (!rows[r].rej) check_frame(rows[r], frames + 1);
      $display("test %0d done", r);
    end
    `CHK("underrun_none", 0, underruns)
    // The first frame ends while the second is still being fed
    f0 = frames;
    send_frame(rows[0], 0);
    send_frame(rows[1], 0);
    check_frame(rows[1], f0 + 2);
    $display("test overlap done");
    f0 = frames;
    send_frame(rows[0], 200);
    check_frame(rows[0], f0 + 1);
    `CHK("underrun_slow", 1'b1, underruns > 0)
    $display("test slow feed done");
    complete_run;
  end
endmodule
`default_nettype wire
